// [rtl/timer16_defs.svh]
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// Register byte addresses
`define OFS_FLAGS       8'h36
`define OFS_IRQ_MASK    8'h6F
`define OFS_CTRL_A      8'h80
`define OFS_CTRL_B      8'h81
`define OFS_CTRL_C      8'h82
`define OFS_COUNT_L     8'h84
`define OFS_COUNT_H     8'h85
`define OFS_CAPTURE_L   8'h86
`define OFS_CAPTURE_H   8'h87
`define OFS_COMPARE_A_L 8'h88
`define OFS_COMPARE_A_H 8'h89
`define OFS_COMPARE_B_L 8'h8A
`define OFS_COMPARE_B_H 8'h8B
`define OFS_COMPARE_C_L 8'h8C
`define OFS_COMPARE_C_H 8'h8D

// Reset values
`define RESET_BYTE      8'h00
`define RESET_WORD      16'h0000

// Control B fields
`define BIT_FILTER_EN   7
`define BIT_EDGE_SEL    6
`define BIT_WAVE_HI     4
`define BIT_WAVE_LO     3
`define CTRL_B_MASK     8'hDF

// Flag and mask bit positions
`define BIT_CAPTURE     5
`define BIT_COMPARE_A   1
`define BIT_OVERFLOW    0
`define FLAG_MASK       8'h2F

// Force strobe of channel A; B and C sit one and two bits lower
`define BIT_FORCE_A     7

// Prescaler tap masks
`define PRESC_MASK_8    10'h007
`define PRESC_MASK_64   10'h03F
`define PRESC_MASK_256  10'h0FF
`define PRESC_MASK_1024 10'h3FF

// Fixed TOP values
`define TOP_MAX         16'hFFFF
`define TOP_8BIT        16'h00FF
`define TOP_9BIT        16'h01FF
`define TOP_10BIT       16'h03FF

// Equal samples needed by the capture filter
`define FILTER_SAMPLES  4

`endif

// [rtl/timer16_pkg.sv]
package timer16_pkg;

  typedef logic [7:0]  byte_type;
  typedef logic [15:0] word_type;

  typedef enum logic [1:0] {
    kind_normal,
    kind_clear_on_match,
    kind_fast_pwm,
    kind_phase_pwm
  } count_kind_type;

endpackage : timer16_pkg

// [rtl/capture_filter_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface capture_filter_if;
  logic sample_in;
  logic enable;
  logic filtered_out;
  modport filter (input sample_in, input enable, output filtered_out);
  modport user   (output sample_in, output enable, input filtered_out);
endinterface : capture_filter_if
`default_nettype wire

// [rtl/capture_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module capture_filter
  import timer16_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  capture_filter_if.filter port
);

  logic [`FILTER_SAMPLES-2:0] hist_reg;
  logic                       out_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= {hist_reg[`FILTER_SAMPLES-3:0], port.sample_in};
    end
  end

  // Output moves only after a full run of equal samples
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      out_reg <= 1'b0;
    end else if ((&{hist_reg, port.sample_in}) || (~|{hist_reg, port.sample_in})) begin
      out_reg <= port.sample_in;
    end
  end

  assign port.filtered_out = port.enable ? out_reg : port.sample_in;

endmodule : capture_filter
`default_nettype wire

// [rtl/timer16_capture_compare_regs.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module timer16_capture_compare_regs
  import timer16_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       capture_input_pin,
  input  wire logic       external_clock_pin,
  input  wire logic       analog_comparator_out,
  input  wire logic       comparator_capture_select,
  input  wire logic       global_irq_enable,
  input  wire logic [7:0] irq_ack,
  output logic      [7:0] irq_request,
  output logic            waveform_output_a,
  output logic            waveform_output_b,
  output logic            waveform_output_c,
  output logic            capture_pin_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  byte_type       ctrl_a_reg;
  byte_type       ctrl_b_reg;
  byte_type       mask_reg;
  byte_type       flag_reg;
  byte_type       flag_set;
  byte_type       flag_clear;
  byte_type       temp_reg;
  byte_type       rdata_reg;
  byte_type       rdata_next;
  word_type       count_reg;
  word_type       count_next;
  word_type       capture_reg;
  word_type       compare_reg [3];
  word_type       top_value;
  count_kind_type kind;
  logic [3:0]     wave_mode;
  logic [2:0]     clock_select;
  logic [9:0]     presc_reg;
  logic [2:0]     wave_reg;
  logic [2:0]     match;
  logic           down_reg;
  logic           down_next;
  logic           block_reg;
  logic           tick;
  logic           top_hit;
  logic           overflow_set;
  logic           pwm_mode;
  logic           capture_is_top;
  logic           capture_event;
  logic           capture_prev_reg;
  logic           cap_sync1_reg;
  logic           cap_sync2_reg;
  logic           ext_sync1_reg;
  logic           ext_sync2_reg;
  logic           ext_prev_reg;
  logic           comp_sync1_reg;
  logic           comp_sync2_reg;
  logic           wr_count_l;
  logic           wr_ctrl_c;

  capture_filter_if filt_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cap_sync1_reg  <= 1'b0;
      cap_sync2_reg  <= 1'b0;
      ext_sync1_reg  <= 1'b0;
      ext_sync2_reg  <= 1'b0;
      ext_prev_reg   <= 1'b0;
      comp_sync1_reg <= 1'b0;
      comp_sync2_reg <= 1'b0;
    end else begin
      cap_sync1_reg  <= capture_input_pin;
      cap_sync2_reg  <= cap_sync1_reg;
      ext_sync1_reg  <= external_clock_pin;
      ext_sync2_reg  <= ext_sync1_reg;
      ext_prev_reg   <= ext_sync2_reg;
      comp_sync1_reg <= analog_comparator_out;
      comp_sync2_reg <= comp_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  assign wave_mode    = {ctrl_b_reg[`BIT_WAVE_HI], ctrl_b_reg[`BIT_WAVE_LO],
                         ctrl_a_reg[1:0]};
  assign clock_select = ctrl_b_reg[2:0];

  always_comb begin
    kind      = kind_normal;
    top_value = `TOP_MAX;
    case (wave_mode)
      4'd1:    begin kind = kind_phase_pwm;      top_value = `TOP_8BIT;  end
      4'd2:    begin kind = kind_phase_pwm;      top_value = `TOP_9BIT;  end
      4'd3:    begin kind = kind_phase_pwm;      top_value = `TOP_10BIT; end
      4'd4:    begin kind = kind_clear_on_match; top_value = compare_reg[0]; end
      4'd5:    begin kind = kind_fast_pwm;       top_value = `TOP_8BIT;  end
      4'd6:    begin kind = kind_fast_pwm;       top_value = `TOP_9BIT;  end
      4'd7:    begin kind = kind_fast_pwm;       top_value = `TOP_10BIT; end
      4'd8:    begin kind = kind_phase_pwm;      top_value = capture_reg; end
      4'd9:    begin kind = kind_phase_pwm;      top_value = compare_reg[0]; end
      4'd10:   begin kind = kind_phase_pwm;      top_value = capture_reg; end
      4'd11:   begin kind = kind_phase_pwm;      top_value = compare_reg[0]; end
      4'd12:   begin kind = kind_clear_on_match; top_value = capture_reg; end
      4'd14:   begin kind = kind_fast_pwm;       top_value = capture_reg; end
      4'd15:   begin kind = kind_fast_pwm;       top_value = compare_reg[0]; end
      default: begin kind = kind_normal;         top_value = `TOP_MAX;  end
    endcase
  end

  assign pwm_mode       = (kind == kind_fast_pwm) || (kind == kind_phase_pwm);
  assign capture_is_top = wave_mode[3] && !wave_mode[0];
  assign capture_pin_enable = !capture_is_top;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and timer clock

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      presc_reg <= 10'h000;
    end else begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  always_comb begin
    case (clock_select)
      3'd0:    tick = 1'b0;
      3'd1:    tick = 1'b1;
      3'd2:    tick = (presc_reg & `PRESC_MASK_8) == `PRESC_MASK_8;
      3'd3:    tick = (presc_reg & `PRESC_MASK_64) == `PRESC_MASK_64;
      3'd4:    tick = (presc_reg & `PRESC_MASK_256) == `PRESC_MASK_256;
      3'd5:    tick = (presc_reg & `PRESC_MASK_1024) == `PRESC_MASK_1024;
      3'd6:    tick = ext_prev_reg && !ext_sync2_reg;
      3'd7:    tick = !ext_prev_reg && ext_sync2_reg;
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting sequence

  assign wr_count_l = reg_write && (reg_addr == `OFS_COUNT_L);
  assign wr_ctrl_c  = reg_write && (reg_addr == `OFS_CTRL_C);
  assign top_hit    = (count_reg == top_value);

  always_comb begin
    count_next   = count_reg;
    down_next    = down_reg;
    overflow_set = 1'b0;
    if (tick) begin
      case (kind)
        kind_normal: begin
          count_next   = count_reg + 16'h0001;
          overflow_set = (count_reg == `TOP_MAX);
        end
        kind_clear_on_match: begin
          count_next   = top_hit ? `RESET_WORD : count_reg + 16'h0001;
          overflow_set = (count_reg == `TOP_MAX);
        end
        kind_fast_pwm: begin
          count_next   = (count_reg >= top_value) ? `RESET_WORD
                                                  : count_reg + 16'h0001;
          overflow_set = (count_reg >= top_value);
        end
        kind_phase_pwm: begin
          if (!down_reg && (count_reg >= top_value)) begin
            down_next  = 1'b1;
            count_next = count_reg - 16'h0001;
          end else if (down_reg && (count_reg == `RESET_WORD)) begin
            down_next    = 1'b0;
            count_next   = count_reg + 16'h0001;
            overflow_set = 1'b1;
          end else begin
            count_next = down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
          end
        end
        default: count_next = count_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= `RESET_WORD;
      down_reg  <= 1'b0;
    end else if (wr_count_l) begin
      count_reg <= {temp_reg, reg_wdata};
    end else begin
      count_reg <= count_next;
      down_reg  <= down_next;
    end
  end

  // Counter write masks the matches of the following timer clock
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      block_reg <= 1'b0;
    end else if (wr_count_l) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture

  assign filt_if.sample_in = comparator_capture_select ? comp_sync2_reg
                                                       : cap_sync2_reg;
  assign filt_if.enable    = ctrl_b_reg[`BIT_FILTER_EN];

  capture_filter u_filter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .port    (filt_if.filter)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      capture_prev_reg <= 1'b0;
    end else begin
      capture_prev_reg <= filt_if.filtered_out;
    end
  end

  assign capture_event = !capture_is_top &&
                         (ctrl_b_reg[`BIT_EDGE_SEL]
                          ? (filt_if.filtered_out && !capture_prev_reg)
                          : (!filt_if.filtered_out && capture_prev_reg));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      capture_reg <= `RESET_WORD;
    end else if (capture_event) begin
      capture_reg <= count_reg;
    end else if (reg_write && (reg_addr == `OFS_CAPTURE_L)) begin
      capture_reg <= {temp_reg, reg_wdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_channel
      localparam logic [7:0] OFS_LOW = 8'(`OFS_COMPARE_A_L + 2 * ch);
      logic [1:0] mode_bits;
      logic       forced;
      logic       match_level;

      assign mode_bits   = ctrl_a_reg[7-2*ch -: 2];
      assign forced      = wr_ctrl_c && reg_wdata[`BIT_FORCE_A-ch] && !pwm_mode;
      assign match[ch]   = tick && !block_reg && !wr_count_l &&
                           (count_reg == compare_reg[ch]);
      assign match_level = (mode_bits == 2'b11) ^
                           ((kind == kind_phase_pwm) && down_reg);

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          compare_reg[ch] <= `RESET_WORD;
        end else if (reg_write && (reg_addr == OFS_LOW)) begin
          compare_reg[ch] <= {temp_reg, reg_wdata};
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          wave_reg[ch] <= 1'b0;
        end else if (!pwm_mode) begin
          if (match[ch] || forced) begin
            case (mode_bits)
              2'b01:   wave_reg[ch] <= !wave_reg[ch];
              2'b10:   wave_reg[ch] <= 1'b0;
              2'b11:   wave_reg[ch] <= 1'b1;
              default: wave_reg[ch] <= wave_reg[ch];
            endcase
          end
        end else if (match[ch]) begin
          if (mode_bits[1]) begin
            wave_reg[ch] <= match_level;
          end else if ((mode_bits == 2'b01) && (ch == 0) && wave_mode[3]) begin
            wave_reg[ch] <= !wave_reg[ch];
          end
        end else if (tick && top_hit && (kind == kind_fast_pwm) && mode_bits[1]) begin
          wave_reg[ch] <= (mode_bits == 2'b10);
        end
      end
    end
  endgenerate

  assign waveform_output_a = wave_reg[0];
  assign waveform_output_b = wave_reg[1];
  assign waveform_output_c = wave_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt requests

  always_comb begin
    flag_set                 = 8'h00;
    flag_set[`BIT_CAPTURE]   = capture_event || (capture_is_top && tick && top_hit);
    flag_set[`BIT_OVERFLOW]  = overflow_set;
    flag_set[`BIT_COMPARE_A+2:`BIT_COMPARE_A] = match;
    flag_clear = irq_ack;
    if (reg_write && (reg_addr == `OFS_FLAGS)) begin
      flag_clear = irq_ack | reg_wdata;
    end
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flag_reg <= `RESET_BYTE;
    end else begin
      flag_reg <= ((flag_reg & ~flag_clear) | flag_set) & `FLAG_MASK;
    end
  end

  assign irq_request = flag_reg & mask_reg & {8{global_irq_enable}};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_a_reg <= `RESET_BYTE;
      ctrl_b_reg <= `RESET_BYTE;
      mask_reg   <= `RESET_BYTE;
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_CTRL_A:   ctrl_a_reg <= reg_wdata;
        `OFS_CTRL_B:   ctrl_b_reg <= reg_wdata & `CTRL_B_MASK;
        `OFS_IRQ_MASK: mask_reg   <= reg_wdata & `FLAG_MASK;
        default:       ctrl_a_reg <= ctrl_a_reg;
      endcase
    end
  end

  // Shared high byte: filled by high writes and by counter and capture low reads
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      temp_reg <= `RESET_BYTE;
    end else if (reg_write && reg_addr[0] && (reg_addr >= `OFS_COUNT_H) &&
                 (reg_addr <= `OFS_COMPARE_C_H)) begin
      temp_reg <= reg_wdata;
    end else if (reg_read && (reg_addr == `OFS_COUNT_L)) begin
      temp_reg <= count_reg[15:8];
    end else if (reg_read && (reg_addr == `OFS_CAPTURE_L)) begin
      temp_reg <= capture_reg[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      `OFS_FLAGS:       rdata_next = flag_reg;
      `OFS_IRQ_MASK:    rdata_next = mask_reg;
      `OFS_CTRL_A:      rdata_next = ctrl_a_reg;
      `OFS_CTRL_B:      rdata_next = ctrl_b_reg;
      `OFS_CTRL_C:      rdata_next = 8'h00;
      `OFS_COUNT_L:     rdata_next = count_reg[7:0];
      `OFS_CAPTURE_L:   rdata_next = capture_reg[7:0];
      `OFS_COMPARE_A_L: rdata_next = compare_reg[0][7:0];
      `OFS_COMPARE_B_L: rdata_next = compare_reg[1][7:0];
      `OFS_COMPARE_C_L: rdata_next = compare_reg[2][7:0];
      `OFS_COMPARE_A_H: rdata_next = compare_reg[0][15:8];
      `OFS_COMPARE_B_H: rdata_next = compare_reg[1][15:8];
      `OFS_COMPARE_C_H: rdata_next = compare_reg[2][15:8];
      `OFS_COUNT_H:     rdata_next = temp_reg;
      `OFS_CAPTURE_H:   rdata_next = temp_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_reg <= `RESET_BYTE;
    end else begin
      rdata_reg <= reg_read ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : timer16_capture_compare_regs
`default_nettype wire

// [bench/timer16_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module timer16_monitor
  import timer16_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       capture_input_pin,
  input wire logic       external_clock_pin,
  input wire logic       analog_comparator_out,
  input wire logic       comparator_capture_select,
  input wire logic       global_irq_enable,
  input wire logic [7:0] irq_ack,
  input wire logic [7:0] irq_request,
  input wire logic       waveform_output_a,
  input wire logic       waveform_output_b,
  input wire logic       waveform_output_c,
  input wire logic       capture_pin_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [3:0] mode_reg;
  ////////////////////////////////////////////////////////////////
  // Shadow of the four waveform mode bits
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      mode_reg <= 4'h0;
    else if (reg_write && reg_addr == `OFS_CTRL_A)
      mode_reg[1:0] <= reg_wdata[1:0];
    else if (reg_write && reg_addr == `OFS_CTRL_B)
      mode_reg[3:2] <= reg_wdata[4:3];
  end
  ////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ctrl_c_zero;
    reg_read && reg_addr == `OFS_CTRL_C |=> reg_rdata == 8'h00;
  endproperty
  a_ctrl_c_zero: assert property (p_ctrl_c_zero) else $error("force bits read back");
  property p_ctrl_b_bit5;
    reg_read && reg_addr == `OFS_CTRL_B |=> !reg_rdata[5];
  endproperty
  a_ctrl_b_bit5: assert property (p_ctrl_b_bit5) else $error("control B bit 5 set");
  property p_mask_res;
    reg_read && reg_addr == `OFS_IRQ_MASK |=> (reg_rdata & 8'hD0) == 8'h00;
  endproperty
  a_mask_res: assert property (p_mask_res) else $error("mask spare bits set");
  property p_global;
    !global_irq_enable |-> irq_request == 8'h00;
  endproperty
  a_global: assert property (p_global) else $error("request while masked");
  property p_cap_en;
    capture_pin_enable == !(mode_reg[3] && !mode_reg[0]);
  endproperty
  a_cap_en: assert property (p_cap_en) else $error("capture pin enable wrong");
  property p_cmp_lo;
    (reg_write && reg_addr == `OFS_COMPARE_A_L) ##1 !reg_write
      ##1 (reg_read && reg_addr == `OFS_COMPARE_A_L) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_cmp_lo: assert property (p_cmp_lo) else $error("compare low lost");
  property p_cmp_hi;
    (reg_write && reg_addr == `OFS_COMPARE_A_H)
      ##1 (reg_write && reg_addr == `OFS_COMPARE_A_L) ##1 !reg_write
      ##1 (reg_read && reg_addr == `OFS_COMPARE_A_L) ##1 !reg_read
      ##1 (reg_read && reg_addr == `OFS_COMPARE_A_H) |=> reg_rdata == $past(reg_wdata, 6);
  endproperty
  a_cmp_hi: assert property (p_cmp_hi) else $error("compare high not latched");
endmodule : timer16_monitor
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module tb_top
  import timer16_pkg::*;
;
  logic     clk_sys, reset_n, reg_write, reg_read, capture_input_pin, external_clock_pin;
  logic     analog_comparator_out, comparator_capture_select, global_irq_enable;
  logic     waveform_output_a, waveform_output_b, waveform_output_c, capture_pin_enable;
  logic     [2:0] wo, wb;
  byte_type reg_addr, reg_wdata, reg_rdata, irq_ack, irq_request, a, b, c;
  word_type w, r, m, prev;
  int       n_fail, n_tests, seed, n;
  int       div[6] = '{2, 1, 8, 64, 256, 1024};
  timer16_capture_compare_regs i_timer16_capture_compare_regs (.*);
  assign wo = {waveform_output_c, waveform_output_b, waveform_output_a};
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input word_type got, input word_type exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input byte_type ad, input byte_type v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_read <= 1'b0;
    reg_write <= 1'b1;
    @(posedge clk_sys);
  endtask : wr
  task automatic idle;
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : idle
  task automatic rd(input byte_type ad, output byte_type v);
    reg_addr <= ad;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic wrw(input byte_type ad, input word_type v);
    wr(ad + 8'h01, v[15:8]);
    wr(ad, v[7:0]);
    idle();
  endtask : wrw
  task automatic rdw(input byte_type ad, output word_type v);
    rd(ad, v[7:0]);
    rd(ad + 8'h01, v[15:8]);
  endtask : rdw
  task automatic capt(input byte_type cb, input logic src, lvl, glitch, hit);
    comparator_capture_select <= src;
    w = word_type'($random(seed));
    wrw(`OFS_COUNT_L, w);
    wr(`OFS_CTRL_B, cb);
    wr(`OFS_FLAGS, 8'h20);
    idle();
    if (src) analog_comparator_out <= lvl;
    else capture_input_pin <= lvl;
    if (glitch) begin
      repeat (2) @(posedge clk_sys);
      capture_input_pin <= !lvl;
    end
    repeat (14) @(posedge clk_sys);
    if (hit) prev = w;
    rdw(`OFS_CAPTURE_L, r);
    chk(r, prev);
    chk(word_type'(irq_request[5]), word_type'(hit));
  endtask : capt
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end
  initial begin
    seed = 32'hcad5_561c;
    {reset_n, reg_write, reg_read, capture_input_pin, external_clock_pin} = 5'h00;
    {analog_comparator_out, comparator_capture_select, global_irq_enable} = 3'h0;
    {reg_addr, reg_wdata, irq_ack, prev} = 40'h00_0000_0000;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (div[i]) begin
      rd((i == 0) ? `OFS_IRQ_MASK : (i == 1) ? `OFS_CTRL_B : byte_type'(8'h86 + i), a);
      chk(word_type'(a), 16'h0000);
    end
    rd(`OFS_CTRL_C, a);
    chk(word_type'(a), 16'h0000);
    wr(`OFS_IRQ_MASK, 8'hFF);
    rd(`OFS_IRQ_MASK, a);
    chk(word_type'(a), 16'h002F);
    for (int i = 0; i < 3; i++) begin
      w = word_type'($random(seed));
      wrw(byte_type'(`OFS_COMPARE_A_L + 2 * i), w);
      rdw(byte_type'(`OFS_COMPARE_A_L + 2 * i), r);
      chk(r, w);
    end
    w = word_type'($random(seed));
    wrw(`OFS_COUNT_L, w);
    rdw(`OFS_COUNT_L, r);
    chk(r, w);
    for (int cs = 0; cs < 6; cs++) begin
      wr(`OFS_CTRL_B, byte_type'(cs));
      rd(`OFS_COUNT_L, a);
      repeat (4 * div[cs] - 2) @(posedge clk_sys);
      rd(`OFS_COUNT_L, b);
      chk(word_type'(byte_type'(b - a)), (cs == 0) ? 16'h0000 : 16'h0004);
    end
    for (int cs = 6; cs < 8; cs++) begin
      wr(`OFS_CTRL_B, byte_type'(cs));
      rd(`OFS_COUNT_L, a);
      external_clock_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(`OFS_COUNT_L, b);
      external_clock_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(`OFS_COUNT_L, c);
      chk(word_type'(byte_type'(b - a)), word_type'(cs == 7));
      chk(word_type'(byte_type'(c - b)), word_type'(cs == 6));
    end
    global_irq_enable <= 1'b1;
    for (int ch = 0; ch < 3; ch++) begin
      m = 16'h0010 + word_type'($random(seed) & 127);
      wr(`OFS_CTRL_B, 8'h00);
      wrw(byte_type'(`OFS_COMPARE_A_L + 2 * ch), m);
      wrw(`OFS_COUNT_L, m);
      wr(`OFS_FLAGS, 8'h2F);
      wr(`OFS_CTRL_B, 8'h01);
      idle();
      repeat (20) @(posedge clk_sys);
      chk(word_type'(irq_request[ch + 1]), 16'h0000);
      wrw(`OFS_COUNT_L, m - 16'h000A);
      n = 0;
      while (irq_request[ch + 1] !== 1'b1 && n < 40) begin
        @(posedge clk_sys);
        n++;
      end
      chk(word_type'(n >= 9 && n <= 12), 16'h0001);
      global_irq_enable <= 1'b0;
      @(posedge clk_sys);
      chk(word_type'(irq_request[ch + 1]), 16'h0000);
      global_irq_enable <= 1'b1;
      irq_ack <= byte_type'(8'h01 << (ch + 1));
      @(posedge clk_sys);
      irq_ack <= 8'h00;
      rd(`OFS_FLAGS, a);
      chk(word_type'(a[ch + 1]), 16'h0000);
    end
    wr(`OFS_CTRL_B, 8'h08);
    wr(`OFS_CTRL_A, 8'h54);
    wrw(`OFS_COUNT_L, w);
    wr(`OFS_FLAGS, 8'h2F);
    for (int ch = 0; ch < 3; ch++) begin
      wb = wo;
      wr(`OFS_CTRL_C, byte_type'(8'h80 >> ch));
      idle();
      chk(word_type'(wo[ch]), word_type'(!wb[ch]));
    end
    rd(`OFS_FLAGS, a);
    chk(word_type'(a & 8'h0E), 16'h0000);
    rdw(`OFS_COUNT_L, r);
    chk(r, w);
    wr(`OFS_CTRL_B, 8'h10);
    wb = wo;
    wr(`OFS_CTRL_C, 8'hE0);
    idle();
    chk(word_type'(wo), word_type'(wb));
    chk(word_type'(capture_pin_enable), 16'h0000);
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h20);
    capt(8'h40, 1'b0, 1'b1, 1'b0, 1'b1);
    capt(8'h40, 1'b0, 1'b0, 1'b0, 1'b0);
    capt(8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    capt(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    capt(8'hC0, 1'b0, 1'b1, 1'b1, 1'b0);
    capt(8'hC0, 1'b0, 1'b1, 1'b0, 1'b1);
    capt(8'h40, 1'b1, 1'b1, 1'b0, 1'b1);
    capt(8'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(`OFS_CTRL_B, 8'h08);
    wrw(`OFS_COMPARE_A_L, 16'h0005);
    wrw(`OFS_COUNT_L, 16'h0000);
    wr(`OFS_CTRL_B, 8'h09);
    idle();
    repeat (19) @(posedge clk_sys);
    rd(`OFS_COUNT_L, a);
    chk(word_type'(a), 16'h0002);
    print_verdict();
  end
endmodule : tb_top
bind timer16_capture_compare_regs timer16_monitor i_timer16_monitor (.*);
`default_nettype wire
